// *** core/irq_ctrl_pkg.sv ***
// Constants, register map and rule summary for the interrupt controller
// What this block does
// - Requests reach the core only while the global enable is one.
// - Any reset clears the global enable.
// - Taking an interrupt clears global enable, pushes return address, vectors to 0004h.
// - Return-from-interrupt leaves the routine and sets the global enable again.
// - Flags set on their event regardless of any interrupt enable bit.
// - Clearing global enable drops next-cycle entries; they stay pending.
// - External events enter the routine three or four instruction cycles later.
// - Edge pin is edge-triggered; polarity bit picks rising or falling; sets pin flag.
// - Pin enable masks the pin interrupt; an enabled edge wakes from sleep.
// - Analog-selected pins read zero and never make edge or change events.
// - Timer rollover FFh to 00h sets overflow flag, gated by its enable.
// - Enabled pin changes set the port-change flag, gated by its enable.
// - A change coinciding with a port access may be lost.
// - The pin flag may be set during the fourth and first sub-phases.
// - Peripheral flags and enables live in their own request and enable registers.
// - Only the return address is saved on entry; no working or status save.
// - Any enabled flagged source wakes from sleep whatever the global enable.
// - On wake with global enable set, run the prefetched instruction, then vector.
package irq_ctrl_pkg;
    // APB byte addresses
    localparam logic [7:0] ADDR_INTCTL  = 8'h00;
    localparam logic [7:0] ADDR_PCF     = 8'h04;
    localparam logic [7:0] ADDR_PCFALL  = 8'h08;
    localparam logic [7:0] ADDR_PCRISE  = 8'h0c;
    localparam logic [7:0] ADDR_LATCH   = 8'h10;
    localparam logic [7:0] ADDR_PEN1    = 8'h14;
    localparam logic [7:0] ADDR_PREQ1   = 8'h18;
    localparam logic [7:0] ADDR_PEN2    = 8'h1c;
    localparam logic [7:0] ADDR_PREQ2   = 8'h20;
    localparam logic [7:0] ADDR_OPTCFG  = 8'h24;
    localparam logic [7:0] ADDR_STATUS  = 8'h28;
    localparam logic [7:0] ADDR_TIMER   = 8'h2c;
    // Control register fields
    localparam int BIT_GIE  = 7;
    localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int BIT_TIE  = 5;
    localparam int BIT_PINE = 4;
    localparam int BIT_CHGE = 3;
    localparam int BIT_TIF  = 2;
    localparam int BIT_PINF = 1;
    localparam int BIT_CHGF = 0;
    // Option/config register fields
    localparam int BIT_EDGE_POL  = 0;
    localparam int BIT_TMR_RUN   = 1;
    localparam int CFG_ANALOG_SELECT_REG_LSB = 8;
    // Reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_ANALOG = 8'h37;
    // Vector and widths
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam int PORT_W = 6;
    localparam int PIN_EDGE_IDX = 2;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    // Entry wait count: the vector loads at the third instruction-cycle end after the request is seen
    localparam logic [1:0] ENTRY_CYCLES = 2'h2;
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_WAIT  = 2'b01,
        ST_SLEEP = 2'b10,
        ST_WAKE  = 2'b11
    } core_state_e;
endpackage

// *** core/pin_sync_edge.sv ***
// Two-flop pin synchroniser with per-pin rise and fall detect
`timescale 1ns/1ps
module pin_sync_edge (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    // Pins and masking
    input  wire logic [irq_ctrl_pkg::PORT_W-1:0]     pinsAsync,
    input  wire logic [irq_ctrl_pkg::PORT_W-1:0]     analogSel,
    // Results
    output logic      [irq_ctrl_pkg::PORT_W-1:0]     pinLevel,
    output logic      [irq_ctrl_pkg::PORT_W-1:0]     roseEvt,
    output logic      [irq_ctrl_pkg::PORT_W-1:0]     fellEvt
);
    import irq_ctrl_pkg::*;
    logic [PORT_W-1:0] meta_reg;
    logic [PORT_W-1:0] sync_reg;
    logic [PORT_W-1:0] prev_reg;

    // Meta flop feeds only the second flop
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pinsAsync;
            sync_reg <= meta_reg;
            prev_reg <= pinLevel;
        end
    end

    // Analog pins read low, so they never toggle
    assign pinLevel = sync_reg & ~analogSel;
    assign roseEvt  = pinLevel & ~prev_reg;
    assign fellEvt  = ~pinLevel & prev_reg;
endmodule

// *** core/irq_ctrl.sv ***
// Interrupt controller with APB registers and core handshake
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module irq_ctrl (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst,
    // APB slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [7:0]                      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // Port pins
    input  wire logic [irq_ctrl_pkg::PORT_W-1:0] portPins,
    // Event sources
    input  wire logic [7:0]                      periphSetOne,
    input  wire logic [7:0]                      periphSetTwo,
    // Core sequencer handshake
    input  wire logic [12:0]                     returnPc,
    input  wire logic                            returnFromIrq,
    input  wire logic                            sleepInstr,
    input  wire logic                            portAccess,
    output logic                                 vectorLoad,
    output logic [12:0]                          vectorAddr,
    output logic                                 stackPush,
    output logic [12:0]                          stackData,
    output logic                                 irqRequest,
    output logic                                 wakeUp,
    output logic                                 sleeping
);
    import irq_ctrl_pkg::*;

    logic [7:0]        intCtl_reg;
    logic [7:0]        pcFlag_reg;
    logic [7:0]        pcFall_reg;
    logic [7:0]        pcRise_reg;
    logic [7:0]        latch_reg;
    logic [7:0]        pen1_reg;
    logic [7:0]        preq1_reg;
    logic [7:0]        pen2_reg;
    logic [7:0]        preq2_reg;
    logic [7:0]        timer_reg;
    logic              edgePol_reg;
    logic              tmrRun_reg;
    logic [7:0]        analog_reg;
    logic [1:0]        phase_reg;
    logic [1:0]        wait_reg;
    logic [1:0]        drop_reg;
    core_state_e       state_reg;
    logic [PORT_W-1:0] pinLevel;
    logic [PORT_W-1:0] roseEvt;
    logic [PORT_W-1:0] fellEvt;
    logic              cycEnd;
    logic              wrEn;
    logic              pinEdge;
    logic [PORT_W-1:0] chgHit;
    logic              tmrWrap;
    logic              srcActive;
    logic              takeIrq;
    logic              gieClrWrite;

    // Register write decode, reused by every process that takes an APB register write
    function automatic logic hit(input logic [7:0] a, input logic [7:0] addr);
        hit = (a == addr);
    endfunction

    pin_sync_edge u_sync (
        .clk       (clk),
        .rst       (rst),
        .pinsAsync (portPins),
        .analogSel (analog_reg[PORT_W-1:0]),
        .pinLevel  (pinLevel),
        .roseEvt   (roseEvt),
        .fellEvt   (fellEvt)
    );

    // Access phase always completes in one cycle
    assign wrEn = psel && penable && pwrite && pready;
    assign cycEnd = (phase_reg == PHASE_Q4);

    // Pin edge accepted in any sub-phase, Q4 through Q1 included
    assign pinEdge = edgePol_reg ? roseEvt[PIN_EDGE_IDX]
                                 : fellEvt[PIN_EDGE_IDX];
    // Change hit only on enabled direction; lost during port access
    assign chgHit = ((roseEvt & pcRise_reg[PORT_W-1:0]) | (fellEvt & pcFall_reg[PORT_W-1:0]))
                    & {PORT_W{~portAccess}};
    assign tmrWrap = tmrRun_reg && cycEnd && (timer_reg == 8'hff);

    // Combined enabled source
    assign srcActive = (intCtl_reg[BIT_TIE] & intCtl_reg[BIT_TIF])
                     | (intCtl_reg[BIT_PINE] & intCtl_reg[BIT_PINF])
                     | (intCtl_reg[BIT_CHGE] & intCtl_reg[BIT_CHGF])
                     | (intCtl_reg[BIT_PERIPHERAL_IRQ_ENABLE] & (|(pen1_reg & preq1_reg)
                                              | |(pen2_reg & preq2_reg)));
    // A software clear of global enable suppresses entry this cycle
    assign gieClrWrite = wrEn && hit(paddr, ADDR_INTCTL) && !pwdata[BIT_GIE];
    assign takeIrq = intCtl_reg[BIT_GIE] && srcActive && !gieClrWrite
                     && (drop_reg == 2'h0);

    // Instruction-cycle phase divider
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= PHASE_Q1;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // Hold-off window after a global clear; requests stay pending
    always_ff @(posedge clk) begin
        if (rst) begin
            drop_reg <= 2'h0;
        end else if (gieClrWrite) begin
            drop_reg <= 2'h1;
        end else if (cycEnd && drop_reg != 2'h0) begin
            drop_reg <= drop_reg - 2'h1;
        end
    end

    // Control register: flags set win over software clears
    always_ff @(posedge clk) begin
        if (rst) begin
            intCtl_reg <= RST_ZERO;
        end else begin
            if (wrEn && hit(paddr, ADDR_INTCTL)) begin
                intCtl_reg <= pwdata[7:0];
            end
            if (state_reg == ST_WAIT && cycEnd && wait_reg == 2'h0) begin
                intCtl_reg[BIT_GIE] <= 1'b0;
            end
            if (returnFromIrq) begin
                intCtl_reg[BIT_GIE] <= 1'b1;
            end
            if (tmrWrap) begin
                intCtl_reg[BIT_TIF] <= 1'b1;
            end
            if (pinEdge) begin
                intCtl_reg[BIT_PINF] <= 1'b1;
            end
            if (|chgHit) begin
                intCtl_reg[BIT_CHGF] <= 1'b1;
            end
        end
    end

    // Per-pin change flags
    always_ff @(posedge clk) begin
        if (rst) begin
            pcFlag_reg <= RST_ZERO;
        end else begin
            if (wrEn && hit(paddr, ADDR_PCF)) begin
                pcFlag_reg <= pwdata[7:0] & 8'h3f;
            end
            pcFlag_reg[PORT_W-1:0] <= (wrEn && hit(paddr, ADDR_PCF)
                                       ? pwdata[PORT_W-1:0] : pcFlag_reg[PORT_W-1:0])
                                      | chgHit;
        end
    end

    // Peripheral request registers, sources set regardless of enables
    always_ff @(posedge clk) begin
        if (rst) begin
            preq1_reg <= RST_ZERO;
            preq2_reg <= RST_ZERO;
        end else begin
            preq1_reg <= (wrEn && hit(paddr, ADDR_PREQ1) ? pwdata[7:0] : preq1_reg)
                         | periphSetOne;
            preq2_reg <= (wrEn && hit(paddr, ADDR_PREQ2) ? pwdata[7:0] : preq2_reg)
                         | periphSetTwo;
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            pcFall_reg  <= RST_ZERO;
            pcRise_reg  <= RST_ZERO;
            latch_reg   <= RST_ZERO;
            pen1_reg    <= RST_ZERO;
            pen2_reg    <= RST_ZERO;
            edgePol_reg <= 1'b1;
            tmrRun_reg  <= 1'b0;
            analog_reg  <= RST_ANALOG;
        end else if (wrEn) begin
            if (hit(paddr, ADDR_PCFALL)) pcFall_reg <= pwdata[7:0] & 8'h3f;
            if (hit(paddr, ADDR_PCRISE)) pcRise_reg <= pwdata[7:0] & 8'h3f;
            if (hit(paddr, ADDR_LATCH))  latch_reg  <= pwdata[7:0] & 8'h37;
            if (hit(paddr, ADDR_PEN1))   pen1_reg   <= pwdata[7:0];
            if (hit(paddr, ADDR_PEN2))   pen2_reg   <= pwdata[7:0];
            if (hit(paddr, ADDR_OPTCFG)) begin
                edgePol_reg <= pwdata[BIT_EDGE_POL];
                tmrRun_reg  <= pwdata[BIT_TMR_RUN];
                analog_reg  <= pwdata[CFG_ANALOG_SELECT_REG_LSB +: 8];
            end
        end
    end

    // 8-bit timer, one count per instruction cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_reg <= RST_ZERO;
        end else if (wrEn && hit(paddr, ADDR_TIMER)) begin
            timer_reg <= pwdata[7:0];
        end else if (tmrRun_reg && cycEnd) begin
            timer_reg <= timer_reg + 8'h01;
        end
    end

    // Core sequencing: run, entry wait, sleep, wake
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_RUN;
            wait_reg  <= 2'h0;
            sleeping  <= 1'b0;
            wakeUp    <= 1'b0;
        end else begin
            wakeUp <= 1'b0;
            case (state_reg)
                ST_RUN: begin
                    if (takeIrq) begin
                        state_reg <= ST_WAIT;
                        wait_reg  <= ENTRY_CYCLES;
                    end else if (sleepInstr) begin
                        state_reg <= ST_SLEEP;
                        sleeping  <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    // Fixed wait keeps latency independent of instruction length
                    if (cycEnd) begin
                        if (wait_reg == 2'h0) begin
                            state_reg <= ST_RUN;
                        end else begin
                            wait_reg <= wait_reg - 2'h1;
                        end
                    end
                end
                ST_SLEEP: begin
                    if (srcActive) begin
                        sleeping  <= 1'b0;
                        wakeUp    <= 1'b1;
                        state_reg <= intCtl_reg[BIT_GIE] ? ST_WAKE : ST_RUN;
                    end
                end
                ST_WAKE: begin
                    // Prefetched instruction runs one cycle before vectoring
                    if (cycEnd) begin
                        state_reg <= ST_WAIT;
                        wait_reg  <= 2'h0;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // Entry strobes; only the return address is saved
    always_ff @(posedge clk) begin
        if (rst) begin
            vectorLoad <= 1'b0;
            vectorAddr <= 13'h0000;
            stackPush  <= 1'b0;
            stackData  <= 13'h0000;
            irqRequest <= 1'b0;
        end else begin
            vectorLoad <= 1'b0;
            stackPush  <= 1'b0;
            irqRequest <= intCtl_reg[BIT_GIE] && srcActive;
            if (state_reg == ST_WAIT && cycEnd && wait_reg == 2'h0) begin
                vectorLoad <= 1'b1;
                vectorAddr <= IRQ_VECTOR;
                stackPush  <= 1'b1;
                stackData  <= returnPc;
            end
        end
    end

    // APB read data, zero-wait answer, error on unmapped address
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    ADDR_INTCTL: prdata[7:0] <= intCtl_reg;
                    ADDR_PCF:    prdata[7:0] <= pcFlag_reg;
                    ADDR_PCFALL: prdata[7:0] <= pcFall_reg;
                    ADDR_PCRISE: prdata[7:0] <= pcRise_reg;
                    ADDR_LATCH:  prdata[7:0] <= latch_reg;
                    ADDR_PEN1:   prdata[7:0] <= pen1_reg;
                    ADDR_PREQ1:  prdata[7:0] <= preq1_reg;
                    ADDR_PEN2:   prdata[7:0] <= pen2_reg;
                    ADDR_PREQ2:  prdata[7:0] <= preq2_reg;
                    ADDR_OPTCFG: prdata[15:0] <= {analog_reg, 6'h00, tmrRun_reg, edgePol_reg};
                    ADDR_STATUS: prdata[PORT_W+3:0] <= {pinLevel, state_reg, sleeping, 1'b0};
                    ADDR_TIMER:  prdata[7:0] <= timer_reg;
                    default:     pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

// *** tb/irq_ctrl_monitor.sv ***
// Port checker for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus and core side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        vectorLoad,
    input wire logic [12:0] vectorAddr,
    input wire logic        stackPush,
    input wire logic        irqRequest,
    input wire logic        wakeUp,
    input wire logic        sleeping
);
    import irq_ctrl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Zero-wait answer after setup
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_vec;
        vectorLoad |-> vectorAddr == IRQ_VECTOR;
    endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_push;
        vectorLoad |-> stackPush;
    endproperty
    a_push: assert property (p_push) else $error("entry without push");
    // Reset must hold the request side quiet, so no disable here
    property p_rstq;
        disable iff (1'b0) rst |=> !irqRequest && !vectorLoad;
    endproperty
    a_rstq: assert property (p_rstq) else $error("request out of reset");
    property p_gie;
        vectorLoad |=> ##1 !irqRequest;
    endproperty
    a_gie: assert property (p_gie) else $error("enable kept on entry");
    property p_lat;
        $rose(irqRequest) |-> ##[1:24] (vectorLoad || !irqRequest);
    endproperty
    a_lat: assert property (p_lat) else $error("entry too late");
    property p_cause;
        vectorLoad |-> $past(irqRequest);
    endproperty
    a_cause: assert property (p_cause) else $error("entry without request");
    property p_wake;
        $fell(sleeping) |-> wakeUp || $past(wakeUp);
    endproperty
    a_wake: assert property (p_wake) else $error("sleep left without wake");
endmodule

bind irq_ctrl irq_ctrl_monitor i_mon (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .vectorLoad(vectorLoad),
    .vectorAddr(vectorAddr), .stackPush(stackPush), .irqRequest(irqRequest),
    .wakeUp(wakeUp), .sleeping(sleeping));

// *** tb/core_seq_model.sv ***
// Core sequencer model: program counter, entry, return and sleep strobes
`timescale 1ns/1ps
module core_seq_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench requests
    input  wire logic        retReq,
    input  wire logic        sleepReq,
    // Controller side
    input  wire logic        vectorLoad,
    input  wire logic [12:0] vectorAddr,
    input  wire logic        stackPush,
    input  wire logic [12:0] stackData,
    output logic      [12:0] returnPc,
    output logic             returnFromIrq,
    output logic             sleepInstr,
    output logic      [7:0]  pushErrs
);
    logic [12:0] savedReg;
    // PC only moves on entry and return, so the pushed value is known
    always_ff @(posedge clk) begin
        if (rst) begin
            returnPc <= 13'h0123;
            savedReg <= 13'h0000;
            pushErrs <= 8'h00;
        end else if (vectorLoad) begin
            returnPc <= vectorAddr;
            savedReg <= stackData;
            if (!stackPush || stackData !== returnPc)
                pushErrs <= pushErrs + 8'h01;
        end else if (retReq) begin
            returnPc <= savedReg;
        end
    end
    // One-cycle instruction strobes
    always_ff @(posedge clk) begin
        returnFromIrq <= retReq && !rst;
        sleepInstr <= sleepReq && !rst;
    end
endmodule

// *** tb/mcu_interrupt_controller_tb.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module mcu_interrupt_controller_tb;
    import irq_ctrl_pkg::*;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] r;
        logic [31:0] m;
    } row_s;
    logic              clk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]        paddr, periphSetOne, periphSetTwo, pushErrs;
    logic [31:0]       pwdata, prdata, q;
    logic [PORT_W-1:0] portPins;
    logic [12:0]       returnPc, vectorAddr, stackData;
    logic              returnFromIrq, sleepInstr, portAccess, vectorLoad, stackPush;
    logic              irqRequest, wakeUp, sleeping, retReq, sleepReq;
    int                fails, samplesChecked, vecCnt, cyc, n0;
    // Rows: address, write, reset value, bit mask
    row_s rows [6] = '{'{ADDR_PCFALL, 32'h2a, 32'h0, 32'h3f},
        '{ADDR_PCRISE, 32'h15, 32'h0, 32'h3f}, '{ADDR_LATCH, 32'h25, 32'h0, 32'h37},
        '{ADDR_PEN1, 32'h41, 32'h0, 32'hcf}, '{ADDR_PEN2, 32'h01, 32'h0, 32'h01},
        '{ADDR_OPTCFG, 32'h01, 32'h3701, 32'hff01}};

    irq_ctrl i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .portPins(portPins), .periphSetOne(periphSetOne), .periphSetTwo(periphSetTwo),
        .returnPc(returnPc), .returnFromIrq(returnFromIrq), .sleepInstr(sleepInstr),
        .portAccess(portAccess), .vectorLoad(vectorLoad), .vectorAddr(vectorAddr),
        .stackPush(stackPush), .stackData(stackData), .irqRequest(irqRequest),
        .wakeUp(wakeUp), .sleeping(sleeping));
    core_seq_model i_core (.clk(clk), .rst(rst), .retReq(retReq), .sleepReq(sleepReq),
        .vectorLoad(vectorLoad), .vectorAddr(vectorAddr), .stackPush(stackPush),
        .stackData(stackData), .returnPc(returnPc), .returnFromIrq(returnFromIrq),
        .sleepInstr(sleepInstr), .pushErrs(pushErrs));

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Entry count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (vectorLoad === 1'b1) vecCnt <= vecCnt + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samplesChecked++;
        if (got !== ex) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until pready is seen at an edge; one idle cycle after
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, ex, q);
    endtask
    task automatic pin(input int i, input logic v);
        portPins[i] <= v;
        tick(4);
    endtask
    task automatic ret;
        retReq <= 1'b1;
        @(posedge clk);
        retReq <= 1'b0;
        tick(4);
    endtask
    task automatic leave;
        wr(ADDR_INTCTL, 32'h0);
        ret();
        wr(ADDR_INTCTL, 32'h0);
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {portPins, periphSetOne, periphSetTwo, portAccess, retReq, sleepReq} = '0;
        {fails, samplesChecked, vecCnt, cyc} = '0;
        rst = 1'b1;
        tick(12);
        rst <= 1'b0;
        @(posedge clk);
        rc("ctl reset", ADDR_INTCTL, 32'h0);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0, q, e);
            chk("reset value", rows[i].r, q & rows[i].m);
            wr(rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0, q, e);
            chk("readback", rows[i].w & rows[i].m, q & rows[i].m);
        end
        wr(ADDR_PCFALL, 32'h0);
        wr(ADDR_PCRISE, 32'h0);
        apb(1'b0, 8'h40, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        // Analog pin gives no edge, then polarity selects the edge
        wr(ADDR_OPTCFG, 32'h0401);
        pin(PIN_EDGE_IDX, 1'b1);
        pin(PIN_EDGE_IDX, 1'b0);
        wr(ADDR_OPTCFG, 32'h0001);
        rc("analog edge", ADDR_INTCTL, 32'h0);
        pin(PIN_EDGE_IDX, 1'b1);
        rc("rise flag", ADDR_INTCTL, 32'h02);
        wr(ADDR_INTCTL, 32'h0);
        wr(ADDR_OPTCFG, 32'h0000);
        pin(PIN_EDGE_IDX, 1'b0);
        rc("fall flag", ADDR_INTCTL, 32'h02);
        // Entry, flag clear by software, return
        wr(ADDR_INTCTL, 32'h0);
        wr(ADDR_OPTCFG, 32'h0001);
        wr(ADDR_INTCTL, 32'h90);
        n0 = vecCnt;
        pin(PIN_EDGE_IDX, 1'b1);
        tick(36);
        chk("entry", n0 + 1, vecCnt);
        rc("enable cleared", ADDR_INTCTL, 32'h12);
        wr(ADDR_INTCTL, 32'h10);
        ret();
        rc("enable set", ADDR_INTCTL, 32'h90);
        tick(36);
        chk("no repeat", n0 + 1, vecCnt);
        // Blocked while disabled, kept pending, taken once enabled
        wr(ADDR_INTCTL, 32'h10);
        pin(PIN_EDGE_IDX, 1'b0);
        pin(PIN_EDGE_IDX, 1'b1);
        tick(36);
        chk("blocked", n0 + 1, vecCnt);
        rc("pending", ADDR_INTCTL, 32'h12);
        wr(ADDR_INTCTL, 32'h92);
        tick(36);
        chk("pending taken", n0 + 2, vecCnt);
        leave();
        // Timer rollover
        wr(ADDR_TIMER, 32'hff);
        wr(ADDR_INTCTL, 32'ha0);
        wr(ADDR_OPTCFG, 32'h0003);
        tick(1200);
        wr(ADDR_OPTCFG, 32'h0001);
        chk("timer entry", n0 + 3, vecCnt);
        rc("timer flag", ADDR_INTCTL, 32'h24);
        leave();
        // Peripheral flags under the peripheral enable
        wr(ADDR_INTCTL, 32'h80);
        periphSetOne <= 8'h01;
        periphSetTwo <= 8'h01;
        @(posedge clk);
        {periphSetOne, periphSetTwo} <= 16'h0;
        tick(36);
        chk("periph masked", n0 + 3, vecCnt);
        rc("request one", ADDR_PREQ1, 32'h01);
        rc("request two", ADDR_PREQ2, 32'h01);
        wr(ADDR_INTCTL, 32'hc0);
        tick(36);
        chk("periph entry", n0 + 4, vecCnt);
        wr(ADDR_PREQ1, 32'h0);
        wr(ADDR_PREQ2, 32'h0);
        leave();
        // Port change, then a change during port access may be lost
        wr(ADDR_PCRISE, 32'h03);
        pin(0, 1'b1);
        rc("change pin", ADDR_PCF, 32'h01);
        rc("change flag", ADDR_INTCTL, 32'h01);
        portAccess <= 1'b1;
        pin(1, 1'b1);
        portAccess <= 1'b0;
        wr(ADDR_PCRISE, 32'h0);
        wr(ADDR_PCF, 32'h0);
        wr(ADDR_INTCTL, 32'h0);
        // Wake from sleep, global enable clear then set
        for (int g = 0; g < 2; g++) begin
            wr(ADDR_INTCTL, g ? 32'h90 : 32'h10);
            sleepReq <= 1'b1;
            @(posedge clk);
            sleepReq <= 1'b0;
            tick(8);
            chk("sleeping", 32'h1, {31'h0, sleeping});
            pin(PIN_EDGE_IDX, 1'b0);
            pin(PIN_EDGE_IDX, 1'b1);
            tick(36);
            chk("woken", 32'h0, {31'h0, sleeping});
            chk("wake entries", n0 + 4 + g, vecCnt);
        end
        // Second reset in mid-run
        wr(ADDR_INTCTL, 32'h80);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        @(posedge clk);
        rc("ctl after reset", ADDR_INTCTL, 32'h0);
        chk("push value", 32'h0, {24'h0, pushErrs});
        report_and_stop();
    end
endmodule
